// file: hw/lsrb_bank.sv
// Register bank for lock status readback, second status pin and loop-two power.
// Assumes a byte-wide register port on i_clk; pin levels arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none

module lsrb_bank
    import lsrb_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    input  wire lsrb_req_t    i_req,
    input  wire logic         i_loop1_lock,
    input  wire logic         i_loop2_lock,
    input  wire lsrb_status_t i_status,
    output logic [7:0]        o_rdata,
    output logic              o_pin_two_out,
    output logic              o_pin_two_oe,
    output logic              o_prescaler_pd,
    output logic              o_loop2_pd
);

    logic [4:0]   select_q;
    logic [2:0]   dtype_q;
    logic [7:0]   fixed_a_q;
    logic [7:0]   fixed_b_q;
    logic         pre_pd_q;
    logic         loop_pd_q;
    logic [7:0]   tuning_a_q;
    logic [7:0]   tuning_b_q;
    logic         hold1_q;
    logic         hold2_q;
    logic [7:0]   rdata_q;
    logic         pin_out_q;
    logic         pin_oe_q;
    lsrb_status_t st_s1_q;
    lsrb_status_t st_s2_q;
    logic         live1;
    logic         lost1;
    logic         live2;
    logic         lost2;
    logic         src_level;
    logic [7:0]   rd_mux;

    // ----------------------------------------------------------------
    // Lost-flag trackers
    // ----------------------------------------------------------------
    lsrb_lost_flag u_loop1 (
        .i_clk        (i_clk),
        .i_srst       (i_srst),
        .i_lock_async (i_loop1_lock),
        .i_hold_clear (hold1_q),
        .o_live       (live1),
        .o_lost       (lost1)
    );

    lsrb_lost_flag u_loop2 (
        .i_clk        (i_clk),
        .i_srst       (i_srst),
        .i_lock_async (i_loop2_lock),
        .i_hold_clear (hold2_q),
        .o_live       (live2),
        .o_lost       (lost2)
    );

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Fixed and tuning values are stored as written; correct values are
    // software's duty, the bank enforces none of them.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            select_q   <= LSRB_RST_SELECT;
            dtype_q    <= LSRB_RST_TYPE;
            fixed_a_q  <= LSRB_RST_FIXED_A;
            fixed_b_q  <= LSRB_RST_FIXED_B;
            pre_pd_q   <= LSRB_RST_POWER[LSRB_PRE_PD_BIT];
            loop_pd_q  <= LSRB_RST_POWER[LSRB_LOOP_PD_BIT];
            tuning_a_q <= LSRB_RST_TUNING;
            tuning_b_q <= LSRB_RST_TUNING;
            hold1_q    <= 1'b0;
            hold2_q    <= 1'b0;
        end else if (i_req.wr) begin
            case (i_req.addr)
                LSRB_ADDR_STATUS2_PIN: begin
                    select_q <= i_req.wdata[LSRB_SEL_MSB:LSRB_SEL_LSB];
                    dtype_q  <= i_req.wdata[LSRB_TYPE_MSB:LSRB_TYPE_LSB];
                end
                LSRB_ADDR_FIXED_A: begin
                    fixed_a_q <= i_req.wdata;
                end
                LSRB_ADDR_FIXED_B: begin
                    fixed_b_q <= i_req.wdata;
                end
                LSRB_ADDR_LOOP2_POWER: begin
                    pre_pd_q  <= i_req.wdata[LSRB_PRE_PD_BIT];
                    loop_pd_q <= i_req.wdata[LSRB_LOOP_PD_BIT];
                end
                LSRB_ADDR_TUNING_A: begin
                    tuning_a_q <= i_req.wdata;
                end
                LSRB_ADDR_TUNING_B: begin
                    tuning_b_q <= i_req.wdata;
                end
                LSRB_ADDR_LOOP1_STATUS: begin
                    hold1_q <= i_req.wdata[LSRB_HOLD_CLEAR_BIT];
                end
                LSRB_ADDR_LOOP2_STATUS: begin
                    hold2_q <= i_req.wdata[LSRB_HOLD_CLEAR_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        case (i_req.addr)
            LSRB_ADDR_STATUS2_PIN: begin
                rd_mux[LSRB_SEL_MSB:LSRB_SEL_LSB]   = select_q;
                rd_mux[LSRB_TYPE_MSB:LSRB_TYPE_LSB] = dtype_q;
            end
            LSRB_ADDR_FIXED_A: begin
                rd_mux = fixed_a_q;
            end
            LSRB_ADDR_FIXED_B: begin
                rd_mux = fixed_b_q;
            end
            LSRB_ADDR_LOOP2_POWER: begin
                rd_mux[LSRB_PRE_PD_BIT]  = pre_pd_q;
                rd_mux[LSRB_LOOP_PD_BIT] = loop_pd_q;
            end
            LSRB_ADDR_TUNING_A: begin
                rd_mux = tuning_a_q;
            end
            LSRB_ADDR_TUNING_B: begin
                rd_mux = tuning_b_q;
            end
            LSRB_ADDR_LOOP1_STATUS: begin
                rd_mux[LSRB_LOST_BIT]       = lost1;
                rd_mux[LSRB_LIVE_BIT]       = live1;
                rd_mux[LSRB_HOLD_CLEAR_BIT] = hold1_q;
            end
            LSRB_ADDR_LOOP2_STATUS: begin
                rd_mux[LSRB_LOST_BIT]       = lost2;
                rd_mux[LSRB_LIVE_BIT]       = live2;
                rd_mux[LSRB_HOLD_CLEAR_BIT] = hold2_q;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // Read data is registered, so it appears the cycle after the strobe.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_q <= 8'h00;
        end else if (i_req.rd) begin
            rdata_q <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Pin source selection
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_s1_q <= '0;
            st_s2_q <= '0;
        end else begin
            st_s1_q <= i_status;
            st_s2_q <= st_s1_q;
        end
    end

    // Divider outputs are only sampled at i_clk; fast dividers alias. The
    // loop-two reference codes rely on software keeping the first pin's
    // selector off its loop-two sources.
    always_comb begin
        src_level = 1'b0;
        case (select_q)
            LSRB_SRC_LOW:      src_level = 1'b0;
            LSRB_SRC_LOOP1:    src_level = live1;
            LSRB_SRC_LOOP2:    src_level = live2;
            LSRB_SRC_BOTH:     src_level = live1 & live2;
            LSRB_SRC_HOLDOVER: src_level = st_s2_q.holdover;
            LSRB_SRC_DAC_LOCK: src_level = st_s2_q.dac_locked;
            LSRB_SRC_READBACK: src_level = st_s2_q.readback;
            LSRB_SRC_DAC_RAIL: src_level = st_s2_q.dac_rail;
            LSRB_SRC_DAC_LOW:  src_level = st_s2_q.dac_low;
            LSRB_SRC_DAC_HIGH: src_level = st_s2_q.dac_high;
            default: begin
                if (select_q >= LSRB_SRC_DIV_FIRST && select_q <= LSRB_SRC_DIV_LAST) begin
                    src_level = st_s2_q.dividers[3'(select_q - LSRB_SRC_DIV_FIRST)];
                end
            end
        endcase
    end

    // Reserved drive types leave the pin undriven.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
        end else begin
            case (dtype_q)
                LSRB_TYPE_PUSH_PULL: begin
                    pin_out_q <= src_level;
                    pin_oe_q  <= 1'b1;
                end
                LSRB_TYPE_INVERTED: begin
                    pin_out_q <= ~src_level;
                    pin_oe_q  <= 1'b1;
                end
                LSRB_TYPE_OPEN_DRN: begin
                    pin_out_q <= 1'b0;
                    pin_oe_q  <= ~src_level;
                end
                default: begin
                    pin_out_q <= 1'b0;
                    pin_oe_q  <= 1'b0;
                end
            endcase
        end
    end

    assign o_rdata        = rdata_q;
    assign o_pin_two_out  = pin_out_q;
    assign o_pin_two_oe   = pin_oe_q;
    assign o_prescaler_pd = pre_pd_q;
    assign o_loop2_pd     = loop_pd_q;

endmodule

`default_nettype wire

// file: hw/lsrb_lost_flag.sv
// Sticky lock-lost flag with live readback for one loop.
// Assumes the lock indication arrives asynchronously to i_clk.
`timescale 1ns/1ns
`default_nettype none

module lsrb_lost_flag
    import lsrb_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_lock_async,
    input  wire logic i_hold_clear,
    output logic      o_live,
    output logic      o_lost
);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic lost_q;

    // ----------------------------------------------------------------
    // Synchroniser and edge history
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= i_lock_async;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // ----------------------------------------------------------------
    // Sticky flag
    // ----------------------------------------------------------------
    // Only a true high-to-low transition sets the flag, so releasing the
    // hold while the lock is already low leaves it clear.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lost_q <= 1'b0;
        end else if (i_hold_clear) begin
            lost_q <= 1'b0;
        end else if (prev_q && !sync2_q) begin
            lost_q <= 1'b1;
        end
    end

    assign o_live = sync2_q;
    assign o_lost = lost_q;

endmodule

`default_nettype wire

// file: hw/lsrb_pkg.sv
// Constants, field layouts and carrier types for the lock status readback bank.
// Assumes a register port that presents a 13-bit address, byte data and strobes.
package lsrb_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [12:0] LSRB_ADDR_STATUS2_PIN   = 13'h016e;
    localparam logic [12:0] LSRB_ADDR_FIXED_A       = 13'h0171;
    localparam logic [12:0] LSRB_ADDR_FIXED_B       = 13'h0172;
    localparam logic [12:0] LSRB_ADDR_LOOP2_POWER   = 13'h0173;
    localparam logic [12:0] LSRB_ADDR_TUNING_A      = 13'h017c;
    localparam logic [12:0] LSRB_ADDR_TUNING_B      = 13'h017d;
    localparam logic [12:0] LSRB_ADDR_LOOP1_STATUS  = 13'h0182;
    localparam logic [12:0] LSRB_ADDR_LOOP2_STATUS  = 13'h0183;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int LSRB_SEL_MSB         = 7;
    localparam int LSRB_SEL_LSB         = 3;
    localparam int LSRB_TYPE_MSB        = 2;
    localparam int LSRB_TYPE_LSB        = 0;
    localparam int LSRB_PRE_PD_BIT      = 6;
    localparam int LSRB_LOOP_PD_BIT     = 5;
    localparam int LSRB_LOST_BIT        = 2;
    localparam int LSRB_LIVE_BIT        = 1;
    localparam int LSRB_HOLD_CLEAR_BIT  = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [4:0] LSRB_RST_SELECT    = 5'h02;
    localparam logic [2:0] LSRB_RST_TYPE      = 3'h6;
    localparam logic [7:0] LSRB_RST_FIXED_A   = 8'h0a;
    localparam logic [7:0] LSRB_RST_FIXED_B   = 8'h00;
    localparam logic [7:0] LSRB_RST_POWER     = 8'h00;
    localparam logic [7:0] LSRB_RST_TUNING    = 8'h00;

    // ----------------------------------------------------------------
    // Source selector and drive type codes
    // ----------------------------------------------------------------
    localparam logic [4:0] LSRB_SRC_LOW        = 5'h00;
    localparam logic [4:0] LSRB_SRC_LOOP1      = 5'h01;
    localparam logic [4:0] LSRB_SRC_LOOP2      = 5'h02;
    localparam logic [4:0] LSRB_SRC_BOTH       = 5'h03;
    localparam logic [4:0] LSRB_SRC_HOLDOVER   = 5'h04;
    localparam logic [4:0] LSRB_SRC_DAC_LOCK   = 5'h05;
    localparam logic [4:0] LSRB_SRC_READBACK   = 5'h07;
    localparam logic [4:0] LSRB_SRC_DAC_RAIL   = 5'h08;
    localparam logic [4:0] LSRB_SRC_DAC_LOW    = 5'h09;
    localparam logic [4:0] LSRB_SRC_DAC_HIGH   = 5'h0a;
    localparam logic [4:0] LSRB_SRC_DIV_FIRST  = 5'h0b;
    localparam logic [4:0] LSRB_SRC_DIV_LAST   = 5'h12;
    localparam logic [2:0] LSRB_TYPE_PUSH_PULL = 3'h3;
    localparam logic [2:0] LSRB_TYPE_INVERTED  = 3'h4;
    localparam logic [2:0] LSRB_TYPE_OPEN_DRN  = 3'h6;

    // Asynchronous status levels that feed the pin selector.
    typedef struct packed {
        logic       holdover;
        logic       dac_locked;
        logic       readback;
        logic       dac_rail;
        logic       dac_low;
        logic       dac_high;
        logic [7:0] dividers;
    } lsrb_status_t;

    // Register port request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [12:0] addr;
        logic [7:0]  wdata;
    } lsrb_req_t;

endpackage

// file: verification/lsrb_monitor.sv
// Port checker for the lock status readback bank, attached by bind.
// Assumes the bank's one-cycle read strobe and registered pin outputs.
`timescale 1ns/1ns
`default_nettype none

module lsrb_monitor
    import lsrb_pkg::*;
(
    input wire logic         i_clk,
    input wire logic         i_srst,
    input wire lsrb_req_t    i_req,
    input wire logic         i_loop1_lock,
    input wire logic         i_loop2_lock,
    input wire lsrb_status_t i_status,
    input wire logic [7:0]   o_rdata,
    input wire logic         o_pin_two_out,
    input wire logic         o_pin_two_oe,
    input wire logic         o_prescaler_pd,
    input wire logic         o_loop2_pd
);
    // ----------------------------------------------------------------
    // Shadow state
    // ----------------------------------------------------------------
    logic [7:0] pin_q;
    logic [7:0] wdata_q;
    logic       mapped;
    logic       pwr_wr;
    assign mapped = i_req.addr inside {LSRB_ADDR_STATUS2_PIN, LSRB_ADDR_FIXED_A,
        LSRB_ADDR_FIXED_B, LSRB_ADDR_LOOP2_POWER, LSRB_ADDR_TUNING_A, LSRB_ADDR_TUNING_B,
        LSRB_ADDR_LOOP1_STATUS, LSRB_ADDR_LOOP2_STATUS};
    assign pwr_wr = i_req.wr && i_req.addr == LSRB_ADDR_LOOP2_POWER;
    always_ff @(posedge i_clk) begin
        wdata_q <= i_req.wdata;
    end
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pin_q <= {LSRB_RST_SELECT, LSRB_RST_TYPE};
        end else if (i_req.wr && i_req.addr == LSRB_ADDR_STATUS2_PIN) begin
            pin_q <= i_req.wdata;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    unmapped_zero_a: assert property (i_req.rd && !mapped |=> o_rdata == 8'h00)
        else $error("unmapped read returned data");
    power_read_a: assert property (i_req.rd && !i_req.wr && i_req.addr == LSRB_ADDR_LOOP2_POWER
        |=> o_rdata == {1'b0, o_prescaler_pd, o_loop2_pd, 5'h00}) else $error("power readback");
    status_resv_a: assert property (i_req.rd && i_req.addr[12:1] == 12'h0c1
        |=> o_rdata[7:3] == 5'h00) else $error("status reserved bits set");
    power_write_a: assert property (pwr_wr |=> {o_prescaler_pd, o_loop2_pd} == wdata_q[6:5])
        else $error("powerdown outputs do not follow write");
    power_keep_a: assert property (!pwr_wr |=> $stable({o_prescaler_pd, o_loop2_pd}))
        else $error("powerdown outputs moved without write");
    open_drain_a: assert property ((pin_q[2:0] == LSRB_TYPE_OPEN_DRN)[*3] |-> !o_pin_two_out)
        else $error("open drain pin driven high");
    push_low_a: assert property ((pin_q == 8'h03)[*3] |-> o_pin_two_oe && !o_pin_two_out)
        else $error("push-pull low source wrong");
    reserved_type_a: assert property ((!(pin_q[2:0] inside {3'h3, 3'h4, 3'h6}))[*3]
        |-> !o_pin_two_oe) else $error("reserved drive type enables pin");
    live_read_a: assert property ($stable(i_loop1_lock)[*5] ##0
        (i_req.rd && i_req.addr == LSRB_ADDR_LOOP1_STATUS) |=> o_rdata[1] == $past(i_loop1_lock))
        else $error("live lock bit wrong");
    reset_quiet_a: assert property ($fell(i_srst) |-> o_rdata == 8'h00 && !o_pin_two_oe
        && !o_prescaler_pd && !o_loop2_pd) else $error("outputs not quiet after reset");
    cover property (i_req.rd && i_req.addr == LSRB_ADDR_LOOP1_STATUS ##1 o_rdata[2]);
    cover property (o_pin_two_oe && o_pin_two_out);
    cover property (o_prescaler_pd && !o_loop2_pd);
endmodule

bind lsrb_bank lsrb_monitor u_mon (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req),
    .i_loop1_lock(i_loop1_lock), .i_loop2_lock(i_loop2_lock), .i_status(i_status),
    .o_rdata(o_rdata), .o_pin_two_out(o_pin_two_out), .o_pin_two_oe(o_pin_two_oe),
    .o_prescaler_pd(o_prescaler_pd), .o_loop2_pd(o_loop2_pd));

`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the lock status readback bank.
// Assumes the bank alone on a 50 MHz clock, driven through its register port.
`timescale 1ns/1ns
`default_nettype none

module tb_top
    import lsrb_pkg::*;
;
    logic         clk      = 1'b0;
    logic         srst     = 1'b1;
    lsrb_req_t    req      = '0;
    logic         l1       = 1'b0;
    logic         l2       = 1'b0;
    lsrb_status_t st       = '0;
    logic [7:0]   rdata;
    logic         pin_out;
    logic         pin_oe;
    logic         pre_pd;
    logic         loop_pd;
    int           errors   = 0;
    int           compares = 0;
    logic [12:0]  ra [9]   = '{13'h16e, 13'h171, 13'h172, 13'h173, 13'h17c, 13'h17d, 13'h182,
                               13'h183, 13'h170};
    logic [7:0]   rv [9]   = '{8'h16, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [12:0]  wa [6]   = '{13'h171, 13'h172, 13'h17c, 13'h17d, 13'h170, 13'h1ff};
    logic [7:0]   wd [6]   = '{8'haa, 8'h02, 8'h15, 8'h33, 8'h55, 8'h77};
    logic [7:0]   pv [4]   = '{8'hff, 8'h40, 8'h20, 8'h00};

    always #10 clk = ~clk;

    lsrb_bank u_dut (.i_clk(clk), .i_srst(srst), .i_req(req), .i_loop1_lock(l1),
        .i_loop2_lock(l2), .i_status(st), .o_rdata(rdata), .o_pin_two_out(pin_out),
        .o_pin_two_oe(pin_oe), .o_prescaler_pd(pre_pd), .o_loop2_pd(loop_pd));

    // ----------------------------------------------------------------
    // Access tasks and expectations
    // ----------------------------------------------------------------
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cyc(input logic w, input logic r, input logic [12:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        req = '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b0;
    endtask
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        cyc(1'b0, 1'b1, a, 8'h00);
        chk($sformatf("register %h", a), e, rdata);
    endtask
    task automatic setlock(input int n, input logic v);
        if (n == 0) l1 = v;
        else l2 = v;
    endtask
    function automatic logic src_exp(int c, logic a, logic b, logic [13:0] s);
        case (c)
            0: return 1'b0;
            1: return a;
            2: return b;
            3: return a & b;
            4, 5: return s[17 - c];
            7, 8, 9, 10: return s[18 - c];
            11, 12, 13, 14, 15, 16, 17, 18: return s[c - 11];
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic [1:0] drv_exp(int t, logic s);
        case (t)
            3: return {1'b1, s};
            4: return {1'b1, ~s};
            6: return {~s, 1'b0};
            default: return 2'b00;
        endcase
    endfunction
    task automatic lost_run(input int n);
        logic [12:0] a;
        a = LSRB_ADDR_LOOP1_STATUS + 13'(n);
        setlock(n, 1'b1);
        idle(5);
        cyc(1'b1, 1'b0, a, 8'h01);
        cyc(1'b1, 1'b0, a, 8'h00);
        rd(a, 8'h02);
        setlock(n, 1'b0);
        idle(6);
        rd(a, 8'h04);
        cyc(1'b1, 1'b0, a, 8'hff);
        idle(2);
        rd(a, 8'h01);
        setlock(n, 1'b1);
        idle(5);
        setlock(n, 1'b0);
        idle(6);
        rd(a, 8'h01);
        cyc(1'b1, 1'b0, a, 8'h00);
        idle(4);
        rd(a, 8'h00);
        setlock(n, 1'b1);
        idle(5);
        setlock(n, 1'b0);
        idle(6);
        rd(a, 8'h04);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        #200000;
        errors++;
        conclude();
    end
    initial begin
        idle(5);
        srst = 1'b0;
        for (int k = 0; k < 9; k++) rd(ra[k], rv[k]);
        $display("test reset values done");
        for (int k = 0; k < 6; k++) cyc(1'b1, 1'b0, wa[k], wd[k]);
        for (int k = 0; k < 6; k++) rd(wa[k], k < 4 ? wd[k] : 8'h00);
        $display("test storage done");
        for (int k = 0; k < 4; k++) begin
            cyc(1'b1, 1'b0, LSRB_ADDR_LOOP2_POWER, pv[k]);
            chk("powerdown pins", {6'h00, pv[k][6:5]}, {6'h00, pre_pd, loop_pd});
            rd(LSRB_ADDR_LOOP2_POWER, pv[k] & 8'h60);
        end
        $display("test power done");
        for (int p = 0; p < 2; p++) begin
            l1 = 1'b1;
            l2 = p[0];
            st = (p == 0) ? 14'h2a55 : 14'h15aa;
            for (int c = 0; c < 20; c++) begin
                cyc(1'b1, 1'b0, LSRB_ADDR_STATUS2_PIN, {c[4:0], LSRB_TYPE_PUSH_PULL});
                idle(4);
                chk("pin source", {7'h00, src_exp(c, l1, l2, st)}, {7'h00, pin_out});
            end
        end
        $display("test pin sources done");
        for (int t = 3; t < 7; t++) begin
            for (int c = 0; c < 2; c++) begin
                cyc(1'b1, 1'b0, LSRB_ADDR_STATUS2_PIN, {c[4:0], t[2:0]});
                idle(4);
                chk("pin drive", {6'h00, drv_exp(t, c[0])}, {6'h00, pin_oe, pin_oe & pin_out});
            end
        end
        $display("test pin drive done");
        lost_run(0);
        lost_run(1);
        $display("test lost flags done");
        srst = 1'b1;
        idle(5);
        srst = 1'b0;
        rd(LSRB_ADDR_STATUS2_PIN, 8'h16);
        rd(LSRB_ADDR_FIXED_A, 8'h0a);
        $display("test second reset done");
        conclude();
    end
endmodule

`default_nettype wire
